// *** design/tcw_pkg.sv ***
package tcw_pkg;

   // Register offsets on the plain register port
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_COUNT = 3'h1;
   localparam logic [2:0] ADDR_COMPARE = 3'h2;
   localparam logic [2:0] ADDR_FLAGS = 3'h3;
   localparam logic [2:0] ADDR_STATE = 3'h4;

   // Control register field positions
   localparam int CTRL_WAVE_LSB = 0;
   localparam int CTRL_OUT_LSB = 2;
   localparam int CTRL_FORCE_BIT = 4;
   localparam int CTRL_DIR_BIT = 5;
   localparam int CTRL_PORT_BIT = 6;

   // Flag register field positions
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CMP_BIT = 1;
   localparam int FLAG_STATE_BIT = 2;
   localparam int STATE_BIT = 0;

   // Counter landmarks and values after reset
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic RESET_BIT = 1'b0;

   // Waveform generation modes
   typedef enum logic [1:0] {
      TCW_NORMAL = 2'h0,
      TCW_PHASE = 2'h1,
      TCW_CTC = 2'h2,
      TCW_FAST = 2'h3
   } tcw_wave_mode_t;

   // Compare output actions
   typedef enum logic [1:0] {
      TCW_OUT_NONE = 2'h0,
      TCW_OUT_TOGGLE = 2'h1,
      TCW_OUT_CLEAR = 2'h2,
      TCW_OUT_SET = 2'h3
   } tcw_out_mode_t;

   // Match action of the non-PWM modes, shared by real and forced matches
   function automatic logic tcw_match_action(input tcw_out_mode_t om, input logic cur);
      case (om)
         TCW_OUT_TOGGLE: tcw_match_action = ~cur;
         TCW_OUT_CLEAR: tcw_match_action = 1'b0;
         TCW_OUT_SET: tcw_match_action = 1'b1;
         default: tcw_match_action = cur;
      endcase
   endfunction : tcw_match_action

endpackage : tcw_pkg

// *** design/tcw_timer.sv ***
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
module tcw_timer (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic timer_tick,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic ovf_service,
   input wire logic cmp_service,
   output logic [7:0] reg_rdata,
   output logic overflow_flag,
   output logic compare_flag,
   output logic pin_out,
   output logic pin_oe
);

   // Configuration state
   tcw_pkg::tcw_wave_mode_t waveform_mode_select;
   tcw_pkg::tcw_out_mode_t compare_output_mode;
   logic pin_direction_bit;
   logic port_data_bit;
   tcw_pkg::tcw_wave_mode_t next_waveform_mode_select;
   tcw_pkg::tcw_out_mode_t next_compare_output_mode;
   logic next_pin_direction_bit;
   logic next_port_data_bit;

   // Counter and compare state
   logic [7:0] counter_value;
   logic [7:0] compare_value;
   logic [7:0] compare_buffer;
   logic match_blocked;
   logic [7:0] next_counter_value;
   logic [7:0] next_compare_value;
   logic [7:0] next_compare_buffer;
   logic next_match_blocked;

   // Flags and compare output state
   logic compare_output_state;
   logic next_overflow_flag;
   logic next_compare_flag;
   logic next_compare_output_state;
   logic [7:0] next_reg_rdata;
   logic next_pin_out;
   logic next_pin_oe;

   // Decoded strobes and events
   logic wr_ctrl;
   logic wr_count;
   logic wr_compare;
   logic wr_flags;
   logic wr_state;
   logic force_compare_strobe;
   logic is_pwm;
   logic match_evt;
   logic bottom_evt;
   logic ovf_evt;
   tcw_pkg::tcw_out_mode_t force_mode;

   // Address decoding
   always_comb begin
      wr_ctrl = 1'b0;
      wr_count = 1'b0;
      wr_compare = 1'b0;
      wr_flags = 1'b0;
      wr_state = 1'b0;
      if (reg_wr && reg_addr == tcw_pkg::ADDR_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (reg_wr && reg_addr == tcw_pkg::ADDR_COUNT) begin
         wr_count = 1'b1;
      end else if (reg_wr && reg_addr == tcw_pkg::ADDR_COMPARE) begin
         wr_compare = 1'b1;
      end else if (reg_wr && reg_addr == tcw_pkg::ADDR_FLAGS) begin
         wr_flags = 1'b1;
      end else if (reg_wr && reg_addr == tcw_pkg::ADDR_STATE) begin
         wr_state = 1'b1;
      end
   end

   // Configuration next values; output mode takes effect at once, acting on later matches
   always_comb begin
      next_waveform_mode_select = waveform_mode_select;
      next_compare_output_mode = compare_output_mode;
      next_pin_direction_bit = pin_direction_bit;
      next_port_data_bit = port_data_bit;
      if (wr_ctrl) begin
         next_waveform_mode_select = tcw_pkg::tcw_wave_mode_t'(reg_wdata[tcw_pkg::CTRL_WAVE_LSB +: 2]);
         next_compare_output_mode = tcw_pkg::tcw_out_mode_t'(reg_wdata[tcw_pkg::CTRL_OUT_LSB +: 2]);
         next_pin_direction_bit = reg_wdata[tcw_pkg::CTRL_DIR_BIT];
         next_port_data_bit = reg_wdata[tcw_pkg::CTRL_PORT_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         waveform_mode_select <= tcw_pkg::TCW_NORMAL;
         compare_output_mode <= tcw_pkg::TCW_OUT_NONE;
         pin_direction_bit <= tcw_pkg::RESET_BIT;
         port_data_bit <= tcw_pkg::RESET_BIT;
      end else begin
         waveform_mode_select <= next_waveform_mode_select;
         compare_output_mode <= next_compare_output_mode;
         pin_direction_bit <= next_pin_direction_bit;
         port_data_bit <= next_port_data_bit;
      end
   end

   // Events seen on a timer clock; a counter write blocks the match one tick later
   always_comb begin
      is_pwm = (waveform_mode_select == tcw_pkg::TCW_FAST);
      match_evt = timer_tick && !match_blocked && (counter_value == compare_value);
      bottom_evt = timer_tick && is_pwm && (counter_value == tcw_pkg::COUNT_MAX) && !wr_count;
      force_compare_strobe = wr_ctrl && reg_wdata[tcw_pkg::CTRL_FORCE_BIT];
      force_mode = tcw_pkg::tcw_out_mode_t'(reg_wdata[tcw_pkg::CTRL_OUT_LSB +: 2]);
   end

   // Counter sequence chosen by waveform mode only; software write has priority
   always_comb begin
      next_counter_value = counter_value;
      next_match_blocked = match_blocked;
      ovf_evt = 1'b0;
      if (timer_tick) begin
         next_match_blocked = 1'b0;
      end
      if (wr_count) begin
         next_counter_value = reg_wdata;
         next_match_blocked = 1'b1;
      end else if (timer_tick) begin
         case (waveform_mode_select)
            tcw_pkg::TCW_CTC: begin
               if (match_evt) begin
                  next_counter_value = tcw_pkg::COUNT_BOTTOM;
               end else begin
                  next_counter_value = counter_value + 8'h01;
               end
               ovf_evt = (counter_value == tcw_pkg::COUNT_MAX);
            end
            tcw_pkg::TCW_FAST: begin
               next_counter_value = counter_value + 8'h01;
               ovf_evt = (next_counter_value == tcw_pkg::COUNT_MAX);
            end
            default: begin
               next_counter_value = counter_value + 8'h01;
               ovf_evt = (next_counter_value == tcw_pkg::COUNT_BOTTOM);
            end
         endcase
      end
   end

   // Compare value: direct outside PWM, buffered and loaded at bottom in fast PWM
   always_comb begin
      next_compare_buffer = compare_buffer;
      next_compare_value = compare_value;
      if (wr_compare) begin
         next_compare_buffer = reg_wdata;
      end
      if (!is_pwm) begin
         next_compare_value = next_compare_buffer;
      end else if (bottom_evt) begin
         next_compare_value = compare_buffer;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         counter_value <= tcw_pkg::RESET_BYTE;
         compare_value <= tcw_pkg::RESET_BYTE;
         compare_buffer <= tcw_pkg::RESET_BYTE;
         match_blocked <= tcw_pkg::RESET_BIT;
      end else begin
         counter_value <= next_counter_value;
         compare_value <= next_compare_value;
         compare_buffer <= next_compare_buffer;
         match_blocked <= next_match_blocked;
      end
   end

   // Flags: a hardware set beats a clear in the same cycle
   always_comb begin
      next_overflow_flag = overflow_flag;
      next_compare_flag = compare_flag;
      if (ovf_service || (wr_flags && reg_wdata[tcw_pkg::FLAG_OVF_BIT])) begin
         next_overflow_flag = 1'b0;
      end
      if (cmp_service || (wr_flags && reg_wdata[tcw_pkg::FLAG_CMP_BIT])) begin
         next_compare_flag = 1'b0;
      end
      if (ovf_evt) begin
         next_overflow_flag = 1'b1;
      end
      if (match_evt) begin
         next_compare_flag = 1'b1;
      end
   end

   // Compare output state; the force strobe never touches flags or counter
   always_comb begin
      next_compare_output_state = compare_output_state;
      if (is_pwm) begin
         if (match_evt) begin
            case (compare_output_mode)
               tcw_pkg::TCW_OUT_TOGGLE: next_compare_output_state = ~compare_output_state;
               tcw_pkg::TCW_OUT_CLEAR: next_compare_output_state = 1'b0;
               tcw_pkg::TCW_OUT_SET: next_compare_output_state = 1'b1;
               default: next_compare_output_state = compare_output_state;
            endcase
         end
         // Bottom wins over a match at MAX, giving the constant level
         if (bottom_evt && compare_output_mode == tcw_pkg::TCW_OUT_CLEAR) begin
            next_compare_output_state = 1'b1;
         end else if (bottom_evt && compare_output_mode == tcw_pkg::TCW_OUT_SET) begin
            next_compare_output_state = 1'b0;
         end
      end else if (force_compare_strobe) begin
         next_compare_output_state = tcw_pkg::tcw_match_action(force_mode, compare_output_state);
      end else if (match_evt && waveform_mode_select != tcw_pkg::TCW_PHASE) begin
         next_compare_output_state = tcw_pkg::tcw_match_action(compare_output_mode, compare_output_state);
      end
      // Phase correct mode is not built here, so real matches leave the output state alone in it; a force strobe still acts
      if (wr_state) begin
         next_compare_output_state = reg_wdata[tcw_pkg::STATE_BIT];
      end
   end

   // Pin mux and read data, all registered so outputs leave flops
   always_comb begin
      // Next mode, so the pin switches source in the same cycle as the mode register
      if (next_compare_output_mode != tcw_pkg::TCW_OUT_NONE) begin
         next_pin_out = next_compare_output_state;
      end else begin
         next_pin_out = next_port_data_bit;
      end
      next_pin_oe = next_pin_direction_bit;
      next_reg_rdata = 8'h00;
      if (reg_rd && reg_addr == tcw_pkg::ADDR_CTRL) begin
         next_reg_rdata = {1'b0, port_data_bit, pin_direction_bit, 1'b0, compare_output_mode, waveform_mode_select};
      end else if (reg_rd && reg_addr == tcw_pkg::ADDR_COUNT) begin
         next_reg_rdata = counter_value;
      end else if (reg_rd && reg_addr == tcw_pkg::ADDR_COMPARE) begin
         next_reg_rdata = compare_buffer;
      end else if (reg_rd && reg_addr == tcw_pkg::ADDR_FLAGS) begin
         next_reg_rdata = {5'h00, compare_output_state, compare_flag, overflow_flag};
      end else if (reg_rd && reg_addr == tcw_pkg::ADDR_STATE) begin
         next_reg_rdata = {7'h00, compare_output_state};
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         overflow_flag <= tcw_pkg::RESET_BIT;
         compare_flag <= tcw_pkg::RESET_BIT;
         compare_output_state <= tcw_pkg::RESET_BIT;
         pin_out <= tcw_pkg::RESET_BIT;
         pin_oe <= tcw_pkg::RESET_BIT;
         reg_rdata <= tcw_pkg::RESET_BYTE;
      end else begin
         overflow_flag <= next_overflow_flag;
         compare_flag <= next_compare_flag;
         compare_output_state <= next_compare_output_state;
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         reg_rdata <= next_reg_rdata;
      end
   end

   // Checks on the built behaviour
   sequence s_plain_tick;
      timer_tick && !reg_wr;
   endsequence

   sequence s_wrap_normal;
      s_plain_tick and (waveform_mode_select == tcw_pkg::TCW_NORMAL && counter_value == tcw_pkg::COUNT_MAX);
   endsequence

   sequence s_fast_bottom;
      s_plain_tick and (waveform_mode_select == tcw_pkg::TCW_FAST && counter_value == tcw_pkg::COUNT_MAX);
   endsequence

   // Counter write followed by one cycle without tick or write
   sequence s_count_write_idle;
      wr_count ##1 (!timer_tick && !reg_wr);
   endsequence

   a_pin_override: assert property (@(posedge ref_clk) disable iff (!reset_n)
      compare_output_mode != tcw_pkg::TCW_OUT_NONE && !reg_wr |=> pin_out == compare_output_state)
      else $error("pin does not follow compare state");

   a_pin_direction: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wr_ctrl |=> pin_oe == $past(reg_wdata[tcw_pkg::CTRL_DIR_BIT]))
      else $error("pin enable differs from direction bit");

   a_port_passthru: assert property (@(posedge ref_clk) disable iff (!reset_n)
      compare_output_mode == tcw_pkg::TCW_OUT_NONE && !reg_wr |=> pin_out == $past(port_data_bit))
      else $error("port value not passed with override off");

   a_normal_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_wrap_normal |=> counter_value == tcw_pkg::COUNT_BOTTOM ##0 overflow_flag)
      else $error("normal mode wrap or overflow wrong");

   a_ctc_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_plain_tick and (waveform_mode_select == tcw_pkg::TCW_CTC && match_evt)
      |=> counter_value == tcw_pkg::COUNT_BOTTOM && compare_flag)
      else $error("clear on match failed");

   a_match_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
      timer_tick && !match_blocked && counter_value == compare_value |=> compare_flag)
      else $error("compare flag not set after match");

   a_write_blocks: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wr_count ##1 (timer_tick && !reg_wr && !compare_flag) |=> !compare_flag)
      else $error("match not blocked after counter write");

   a_write_blocks_late: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_count_write_idle ##1 (timer_tick && !reg_wr && !compare_flag) |=> !compare_flag)
      else $error("match not blocked on first tick after write");

   a_fast_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_fast_bottom and (compare_output_mode == tcw_pkg::TCW_OUT_CLEAR) |=> compare_output_state)
      else $error("fast pwm did not set at bottom");

   a_fast_ovf: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_plain_tick and (waveform_mode_select == tcw_pkg::TCW_FAST
      && counter_value == 8'hfe) |=> overflow_flag && counter_value == tcw_pkg::COUNT_MAX)
      else $error("fast pwm overflow missing at max");

   a_force_toggle: assert property (@(posedge ref_clk) disable iff (!reset_n)
      force_compare_strobe && waveform_mode_select != tcw_pkg::TCW_FAST && force_mode == tcw_pkg::TCW_OUT_TOGGLE
      && !compare_flag && !timer_tick |=> compare_output_state != $past(compare_output_state) && !compare_flag)
      else $error("force strobe misbehaved");

   a_none_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
      compare_output_mode == tcw_pkg::TCW_OUT_NONE && !reg_wr |=> $stable(compare_output_state))
      else $error("output mode zero changed state");

endmodule : tcw_timer

// *** testbench/tcw_pin_load.sv ***
`timescale 1ns/10ps
// External load on the compare pin, with a weak pull-up on the line
module tcw_pin_load (
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_level
);
   // A released pin shows the pull-up level, never the last driven value
   assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule : tcw_pin_load

// *** testbench/tcw_tb.sv ***
`timescale 1ns/10ps
module testbench;
   localparam logic [2:0] A_CTL = tcw_pkg::ADDR_CTRL;
   localparam logic [2:0] A_CNT = tcw_pkg::ADDR_COUNT;
   localparam logic [2:0] A_CMP = tcw_pkg::ADDR_COMPARE;
   localparam logic [2:0] A_FLG = tcw_pkg::ADDR_FLAGS;
   localparam logic [2:0] A_ST = tcw_pkg::ADDR_STATE;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic timer_tick = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ovf_service = 1'b0;
   logic cmp_service = 1'b0;
   logic [7:0] reg_rdata;
   logic overflow_flag;
   logic compare_flag;
   logic pin_out;
   logic pin_oe;
   logic pin_level;
   int error_cnt = 0;
   int cmp_count = 0;

   // 250 MHz reference clock
   always #2 ref_clk = ~ref_clk;

   tcw_timer dut (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .timer_tick(timer_tick),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .ovf_service(ovf_service),
      .cmp_service(cmp_service),
      .reg_rdata(reg_rdata),
      .overflow_flag(overflow_flag),
      .compare_flag(compare_flag),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );

   tcw_pin_load load (
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .pin_level(pin_level)
   );

   // Comparisons, one per kind of result
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t byte %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t bit %b expected %b", $time, got, exp);
      end
   endtask : chk1

   // Register port cycles; each leaves one idle cycle so strobes never repeat in a step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk8(reg_rdata, exp);
   endtask : rd

   // Run n timer clocks back to back, prescale of one
   task automatic tick(input int n);
      @(posedge ref_clk);
      timer_tick <= 1'b1;
      repeat (n) @(posedge ref_clk);
      timer_tick <= 1'b0;
      #1;
   endtask : tick

   task automatic svc(input logic o, input logic c);
      @(posedge ref_clk);
      ovf_service <= o;
      cmp_service <= c;
      @(posedge ref_clk);
      ovf_service <= 1'b0;
      cmp_service <= 1'b0;
      #1;
   endtask : svc

   function automatic logic [7:0] ctrl(input logic [1:0] w, input logic [1:0] o, input logic f, input logic d);
      ctrl = 8'h00;
      ctrl[tcw_pkg::CTRL_WAVE_LSB +: 2] = w;
      ctrl[tcw_pkg::CTRL_OUT_LSB +: 2] = o;
      ctrl[tcw_pkg::CTRL_FORCE_BIT] = f;
      ctrl[tcw_pkg::CTRL_DIR_BIT] = d;
   endfunction : ctrl

   task automatic tally_and_finish;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   // Watchdog against a hang anywhere in the sequence
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      $display("ERROR %0t run did not complete", $time);
      tally_and_finish();
   end

   initial begin
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      // Reset values, then an unmapped index
      for (int a = 0; a < 5; a++) rd(3'(a), 8'h00);
      chk1(pin_oe, 1'b0);
      wr(3'h5, 8'h5a);
      rd(3'h5, 8'h00);
      // Normal mode wrap and sticky overflow
      wr(A_CNT, 8'hff);
      tick(1);
      rd(A_CNT, 8'h00);
      chk1(overflow_flag, 1'b1);
      tick(3);
      chk1(overflow_flag, 1'b1);
      chk1(compare_flag, 1'b1);
      svc(1'b1, 1'b1);
      chk1(overflow_flag, 1'b0);
      chk1(compare_flag, 1'b0);
      wr(A_CNT, 8'h80);
      rd(A_CNT, 8'h80);
      // Preset state, then pin source selection
      wr(A_ST, 8'h01);
      wr(A_CTL, ctrl(2'h0, 2'h0, 1'b0, 1'b1));
      chk1(pin_oe, 1'b1);
      chk1(pin_level, 1'b0);
      wr(A_CTL, ctrl(2'h0, 2'h1, 1'b0, 1'b1));
      chk1(pin_level, 1'b1);
      wr(A_CTL, ctrl(2'h2, 2'h1, 1'b0, 1'b1));
      chk1(pin_level, 1'b1);
      // Forced match toggles state without flag or clear
      wr(A_CTL, ctrl(2'h0, 2'h1, 1'b1, 1'b1));
      rd(A_ST, 8'h00);
      chk1(compare_flag, 1'b0);
      rd(A_CNT, 8'h80);
      wr(A_CTL, ctrl(2'h0, 2'h0, 1'b1, 1'b1));
      rd(A_ST, 8'h00);
      wr(A_CTL, ctrl(2'h0, 2'h1, 1'b0, 1'b0));
      chk1(pin_oe, 1'b0);
      chk1(pin_level, 1'b1);
      // Clear-on-match with toggle output
      wr(A_CMP, 8'h03);
      wr(A_CTL, ctrl(2'h2, 2'h1, 1'b0, 1'b1));
      wr(A_CNT, 8'h00);
      tick(3);
      rd(A_CNT, 8'h03);
      chk1(compare_flag, 1'b0);
      tick(1);
      rd(A_CNT, 8'h00);
      chk1(compare_flag, 1'b1);
      chk1(pin_level, 1'b1);
      svc(1'b0, 1'b1);
      chk1(compare_flag, 1'b0);
      tick(4);
      chk1(pin_level, 1'b0);
      chk1(overflow_flag, 1'b0);
      // Count write masks the next match
      wr(A_FLG, 8'h03);
      wr(A_CNT, 8'h03);
      tick(1);
      rd(A_CNT, 8'h04);
      chk1(compare_flag, 1'b0);
      // Compare below count: run to the top and wrap first
      tick(251);
      rd(A_CNT, 8'hff);
      tick(1);
      chk1(overflow_flag, 1'b1);
      chk1(compare_flag, 1'b0);
      tick(4);
      chk1(compare_flag, 1'b1);
      // Fast PWM, both polarities, buffered compare
      for (int om = 2; om <= 3; om++) begin
         wr(A_FLG, 8'h03);
         wr(A_CTL, ctrl(2'h3, 2'(om), 1'b0, 1'b1));
         wr(A_CMP, 8'h80);
         wr(A_CNT, 8'hfe);
         tick(1);
         chk1(overflow_flag, 1'b1);
         tick(1);
         rd(A_CNT, 8'h00);
         chk1(pin_level, om == 2);
         tick(128);
         chk1(pin_level, om == 2);
         tick(1);
         chk1(pin_level, om != 2);
         chk1(compare_flag, 1'b1);
         wr(A_CMP, 8'h10);
         rd(A_CMP, 8'h10);
         tick(127);
         rd(A_CNT, 8'h00);
         chk1(pin_level, om == 2);
         tick(16);
         chk1(pin_level, om == 2);
         tick(1);
         chk1(pin_level, om != 2);
      end
      // Extreme compare values: spike at zero, constant at maximum
      wr(A_CTL, ctrl(2'h3, 2'h2, 1'b0, 1'b1));
      wr(A_CMP, 8'h00);
      tick(239);
      chk1(pin_level, 1'b1);
      tick(1);
      chk1(pin_level, 1'b0);
      wr(A_CMP, 8'hff);
      tick(255);
      for (int i = 0; i < 256; i++) begin
         tick(1);
         chk1(pin_level, 1'b1);
      end
      // Fast PWM toggle at MAX, then the unbuilt dual-slope mode still counts and overflows but leaves the output alone
      wr(A_CTL, ctrl(2'h3, 2'h1, 1'b0, 1'b1));
      tick(256);
      chk1(pin_level, 1'b0);
      tick(256);
      chk1(pin_level, 1'b1);
      wr(A_FLG, 8'h03);
      wr(A_CTL, ctrl(2'h1, 2'h2, 1'b0, 1'b1));
      tick(256);
      chk1(pin_level, 1'b1);
      chk1(overflow_flag, 1'b1);
      rd(A_CNT, 8'h00);
      tally_and_finish();
   end
endmodule : testbench
